// ===== src/twg_pkg.sv
// Purpose: Shared constants for the two-wire register write guard
// Assumes: Processor clock select is a 3-bit code, 24 MHz down to 93 K
// Notes: Matrix row is the status/control write setting, column the config write setting
package twg_pkg;

  // ---------------------------------------------------------------
  // Processor clock select codes
  // ---------------------------------------------------------------
  localparam logic [2:0] FREQ_24M = 3'h0;
  localparam logic [2:0] FREQ_12M = 3'h1;
  localparam logic [2:0] FREQ_6M = 3'h2;
  localparam logic [2:0] FREQ_3M = 3'h3;
  localparam logic [2:0] FREQ_1M5 = 3'h4;
  localparam logic [2:0] FREQ_375K = 3'h5;
  localparam logic [2:0] FREQ_180K = 3'h6;
  localparam logic [2:0] FREQ_93K = 3'h7;

  // ---------------------------------------------------------------
  // Allowed combinations: bit c of row r set when config at c and
  // status/control at r is recommended
  // ---------------------------------------------------------------
  localparam logic [7:0] ROW_24M = 8'h00;
  localparam logic [7:0] ROW_12M = 8'h3c;
  localparam logic [7:0] ROW_6M = 8'h26;
  localparam logic [7:0] ROW_SLOW = 8'hfa;

  // Config write alone is recommended at some status/control setting
  localparam logic [7:0] CFG_ANY_OK = 8'hfe;

  // Reset value of the recorded config-write setting
  localparam logic [2:0] CFG_FREQ_RESET = 3'h0;

  // Register targets of a write
  typedef enum logic [1:0] {
    TWG_TGT_CFG = 2'h0,
    TWG_TGT_SLAVE_SC = 2'h1,
    TWG_TGT_MASTER_SC = 2'h3
  } twg_target_type;

endpackage

// ===== src/twg_write_guard.sv
// Purpose: Qualifies writes to the two-wire config and status/control registers
// Assumes: Write strobes are synchronous one-cycle pulses in the processor clock domain
// Notes: Flagged writes are still forwarded; software owns recovery
`timescale 1ns/1ns
module twg_write_guard (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // Processor clock setting
  input wire logic [2:0] cpu_freq_sel,
  // Protected register write strobes
  input wire logic cfg_write,
  input wire logic slave_sc_write,
  input wire logic master_sc_write,
  // Qualified results
  output logic write_accepted,
  output logic false_write,
  output logic [1:0] false_target,
  output logic [2:0] cfg_freq_recorded
);

  // ---------------------------------------------------------------
  // Matrix lookup
  // ---------------------------------------------------------------
  logic [2:0] cfg_freq_q;
  logic [2:0] cfg_freq_d;
  logic [7:0] sc_row;
  logic sc_write;
  logic any_write;
  logic cfg_ok;
  logic sc_ok;
  logic bad_write;
  logic [1:0] target;
  logic accepted_q;
  logic false_q;
  logic [1:0] target_q;

  assign sc_row = (cpu_freq_sel == twg_pkg::FREQ_24M) ? twg_pkg::ROW_24M :
                  (cpu_freq_sel == twg_pkg::FREQ_12M) ? twg_pkg::ROW_12M :
                  (cpu_freq_sel == twg_pkg::FREQ_6M) ? twg_pkg::ROW_6M :
                  twg_pkg::ROW_SLOW;

  assign sc_write = slave_sc_write | master_sc_write;
  assign any_write = cfg_write | sc_write;
  assign sc_ok = sc_row[cfg_freq_q];
  // A config write is judged alone: no cell allows it at 24 MHz
  assign cfg_ok = twg_pkg::CFG_ANY_OK[cpu_freq_sel];
  assign bad_write = (cfg_write & ~cfg_ok) | (sc_write & ~sc_ok);
  assign target = cfg_write ? twg_pkg::TWG_TGT_CFG :
                  master_sc_write ? twg_pkg::TWG_TGT_MASTER_SC :
                  twg_pkg::TWG_TGT_SLAVE_SC;

  assign cfg_freq_d = cfg_write ? cpu_freq_sel : cfg_freq_q;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_freq_q <= twg_pkg::CFG_FREQ_RESET;
      accepted_q <= 1'b0;
      false_q <= 1'b0;
      target_q <= 2'h0;
    end else if (clk_en) begin
      cfg_freq_q <= cfg_freq_d;
      accepted_q <= any_write & ~bad_write;
      false_q <= any_write & bad_write;
      target_q <= any_write ? target : target_q;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign write_accepted = accepted_q;
  assign false_write = false_q;
  assign false_target = target_q;
  assign cfg_freq_recorded = cfg_freq_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sc_24m_never_a: assert property (@(posedge clk) disable iff (reset)
    (clk_en && sc_write && !cfg_write && cpu_freq_sel == 3'h0) |=> false_write)
    else $error("status/control write at 24 MHz not flagged");

  sc_12m_matrix_a: assert property (@(posedge clk) disable iff (reset)
    (clk_en && sc_write && !cfg_write && cpu_freq_sel == 3'h1)
      |=> (false_write == !($past(cfg_freq_q) inside {3'h2, 3'h3, 3'h4, 3'h5})))
    else $error("12 MHz status/control check wrong");

  sc_6m_matrix_a: assert property (@(posedge clk) disable iff (reset)
    (clk_en && sc_write && !cfg_write && cpu_freq_sel == 3'h2)
      |=> (false_write == !($past(cfg_freq_q) inside {3'h1, 3'h2, 3'h5})))
    else $error("6 MHz status/control check wrong");

  sc_slow_matrix_a: assert property (@(posedge clk) disable iff (reset)
    (clk_en && sc_write && !cfg_write && cpu_freq_sel >= 3'h3)
      |=> (false_write == ($past(cfg_freq_q) inside {3'h0, 3'h2})))
    else $error("slow status/control check wrong");

  cfg_record_a: assert property (@(posedge clk) disable iff (reset)
    (clk_en && cfg_write) |=> (cfg_freq_recorded == $past(cpu_freq_sel)))
    else $error("config write setting not recorded");

  cfg_hold_a: assert property (@(posedge clk) disable iff (reset)
    (!cfg_write || !clk_en) |=> $stable(cfg_freq_recorded))
    else $error("recorded setting changed without config write");

  flag_exclusive_a: assert property (@(posedge clk) disable iff (reset)
    !(false_write && write_accepted))
    else $error("write both accepted and flagged");

  write_outcome_a: assert property (@(posedge clk) disable iff (reset)
    (clk_en && (cfg_write || slave_sc_write || master_sc_write))
      |=> (false_write || write_accepted))
    else $error("protected write produced no outcome");

  cfg_24m_false_a: assert property (@(posedge clk) disable iff (reset)
    (clk_en && cfg_write && cpu_freq_sel == 3'h0) |=> (false_write && false_target == 2'h0))
    else $error("config write at 24 MHz not flagged");

  // ---------------------------------------------------------------
  // Checks: reset, clock enable, idle and single writes
  // ---------------------------------------------------------------
  // A low enable keeps the last outcome standing; consumers gate it with clk_en
  reset_clear_a: assert property (@(posedge clk)
    $fell(reset) |-> (cfg_freq_recorded == 3'h0 && false_target == 2'h0
      && !false_write && !write_accepted))
    else $error("outputs not cleared by reset");

  write_frozen_a: assert property (@(posedge clk) disable iff (reset)
    !clk_en
      |=> ($stable(false_write) && $stable(write_accepted) && $stable(false_target)))
    else $error("outcome changed while enable low");

  idle_quiet_a: assert property (@(posedge clk) disable iff (reset)
    (clk_en && !cfg_write && !slave_sc_write && !master_sc_write)
      |=> (!false_write && !write_accepted))
    else $error("outcome without a write");

  cfg_alone_ok_a: assert property (@(posedge clk) disable iff (reset)
    (clk_en && cfg_write && !sc_write && cpu_freq_sel != 3'h0)
      |=> (write_accepted && false_target == 2'h0))
    else $error("config write at a usable setting not accepted");

  cfg_24m_reject_a: assert property (@(posedge clk) disable iff (reset)
    (clk_en && cfg_write && cpu_freq_sel == 3'h0)
      |=> !write_accepted)
    else $error("config write at 24 MHz accepted");

  accepted_24m_never_a: assert property (@(posedge clk) disable iff (reset)
    (write_accepted && $past(clk_en))
      |-> ($past(cpu_freq_sel) != 3'h0))
    else $error("write accepted at 24 MHz");

  sc_no_record_a: assert property (@(posedge clk) disable iff (reset)
    (clk_en && sc_write && !cfg_write)
      |=> $stable(cfg_freq_recorded))
    else $error("status/control write changed the record");

  // ---------------------------------------------------------------
  // Checks: combined writes
  // ---------------------------------------------------------------
  // Both strobes in one cycle: the config part is judged alone and the
  // status/control part against the record from before this write
  sc_24m_reject_a: assert property (@(posedge clk) disable iff (reset)
    (clk_en && sc_write && cpu_freq_sel == 3'h0)
      |=> (false_write && !write_accepted))
    else $error("status/control write at 24 MHz accepted");

  both_12m_old_a: assert property (@(posedge clk) disable iff (reset)
    (clk_en && sc_write && cfg_write && cpu_freq_sel == 3'h1)
      |=> (false_write == !($past(cfg_freq_q) inside {3'h2, 3'h3, 3'h4, 3'h5})))
    else $error("12 MHz combined write misjudged");

  both_6m_old_a: assert property (@(posedge clk) disable iff (reset)
    (clk_en && sc_write && cfg_write && cpu_freq_sel == 3'h2)
      |=> (false_write == !($past(cfg_freq_q) inside {3'h1, 3'h2, 3'h5})))
    else $error("6 MHz combined write misjudged");

  both_slow_old_a: assert property (@(posedge clk) disable iff (reset)
    (clk_en && sc_write && cfg_write && cpu_freq_sel >= 3'h3)
      |=> (false_write == ($past(cfg_freq_q) inside {3'h0, 3'h2})))
    else $error("slow combined write misjudged");

  // ---------------------------------------------------------------
  // Checks: target
  // ---------------------------------------------------------------
  // Config wins the target when strobes coincide; slave and master together
  // are never strobed, and master would win their shared target
  tgt_cfg_a: assert property (@(posedge clk) disable iff (reset)
    (clk_en && cfg_write && sc_write)
      |=> (false_target == 2'h0))
    else $error("config target not shown");

  tgt_master_a: assert property (@(posedge clk) disable iff (reset)
    (clk_en && master_sc_write && !cfg_write)
      |=> (false_target == 2'h3))
    else $error("master target not shown");

  tgt_slave_a: assert property (@(posedge clk) disable iff (reset)
    (clk_en && slave_sc_write && !master_sc_write && !cfg_write)
      |=> (false_target == 2'h1))
    else $error("slave target not shown");

  tgt_hold_a: assert property (@(posedge clk) disable iff (reset)
    (clk_en && !cfg_write && !slave_sc_write && !master_sc_write)
      |=> $stable(false_target))
    else $error("target changed without a write");

endmodule

// ===== verification/tb_top.sv
// Purpose: Self-checking bench for the two-wire register write guard
// Assumes: Outcome pulses come one cycle after the strobe edge
// Notes: Never strobes slave and master together; that target would be master
`timescale 1ns/1ns
module tb_top;
  // ----------------------------------------------------------------
  // Signals and model state
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b0;
  logic [2:0] cpu_freq_sel = 3'h0;
  logic cfg_write = 1'b0;
  logic slave_sc_write = 1'b0;
  logic master_sc_write = 1'b0;
  logic write_accepted;
  logic false_write;
  logic [1:0] false_target;
  logic [2:0] cfg_freq_recorded;
  logic acc_e = 1'b0;
  logic fw_e = 1'b0;
  logic [1:0] tgt_e = 2'h0;
  logic [2:0] rec_e = 3'h0;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int seed = 71323;
  logic [31:0] r;

  twg_write_guard dut_u (.clk(clk), .reset(reset), .clk_en(clk_en), .cpu_freq_sel(cpu_freq_sel),
    .cfg_write(cfg_write), .slave_sc_write(slave_sc_write), .master_sc_write(master_sc_write),
    .write_accepted(write_accepted), .false_write(false_write), .false_target(false_target),
    .cfg_freq_recorded(cfg_freq_recorded));

  always #5 clk = ~clk;

  // Hang guard well above the planned 762 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_count = err_count + 1;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // Expectation and checking helpers
  // ----------------------------------------------------------------
  // allowed combinations
  function automatic logic rec_ok(input logic [2:0] sc, input logic [2:0] cf);
    if (sc == 3'h0 || cf == 3'h0) return 1'b0;
    if (sc == 3'h1) return cf inside {3'h2, 3'h3, 3'h4, 3'h5};
    if (sc == 3'h2) return cf inside {3'h1, 3'h2, 3'h5};
    return cf != 3'h2;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Checks the previous write's outcome, then drives the next one
  task automatic step(input logic en, c, s, m, input logic [2:0] sel);
    logic ok;
    logic any;
    @(negedge clk);
    chk({7'h0, write_accepted}, {7'h0, acc_e});
    chk({7'h0, false_write}, {7'h0, fw_e});
    chk({6'h0, false_target}, {6'h0, tgt_e});
    chk({5'h0, cfg_freq_recorded}, {5'h0, rec_e});
    any = en && (c || s || m);
    ok = (s || m) ? rec_ok(sel, rec_e) : 1'b1;
    if (c) ok = ok && (sel != 3'h0);
    // A low enable freezes the outcome pulses, so the old ones stand
    if (en) acc_e = any && ok;
    if (en) fw_e = any && !ok;
    if (any) tgt_e = c ? 2'h0 : (m ? 2'h3 : 2'h1);
    if (en && c) rec_e = sel;
    clk_en = en;
    cfg_write = c;
    slave_sc_write = s;
    master_sc_write = m;
    cpu_freq_sel = sel;
  endtask

  // Mid-run reset: strobes are dropped first so the reset edges see none
  task automatic do_reset(input int n);
    step(1'b0, 1'b0, 1'b0, 1'b0, 3'h0);
    reset = 1'b1;
    repeat (n) @(negedge clk);
    reset = 1'b0;
    acc_e = 1'b0;
    fw_e = 1'b0;
    tgt_e = 2'h0;
    rec_e = 3'h0;
  endtask

  task automatic end_sim();
    $display("errors=%0d compares=%0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(negedge clk);
    reset = 1'b0;
    step(1'b1, 1'b0, 1'b1, 1'b0, 3'h3);
    for (int cf = 0; cf < 8; cf++) begin
      for (int sc = 0; sc < 8; sc++) begin
        step(1'b1, 1'b1, 1'b0, 1'b0, cf[2:0]);
        step(1'b1, 1'b0, sc[0], !sc[0], sc[2:0]);
      end
    end
    // Firmware pattern: drop to a recommended setting, write, then restore
    step(1'b1, 1'b0, 1'b0, 1'b0, 3'h0);
    step(1'b1, 1'b1, 1'b0, 1'b0, 3'h1);
    step(1'b1, 1'b0, 1'b0, 1'b0, 3'h0);
    step(1'b1, 1'b0, 1'b0, 1'b1, 3'h3);
    step(1'b1, 1'b0, 1'b1, 1'b0, 3'h0);
    step(1'b0, 1'b1, 1'b0, 1'b0, 3'h0);
    repeat (600) begin
      r = $random(seed);
      step(r[5:3] != 3'h0, r[0], r[1] & ~r[2], r[1] & r[2], r[8:6]);
    end
    do_reset(3);
    step(1'b1, 1'b0, 1'b1, 1'b0, 3'h3);
    step(1'b0, 1'b0, 1'b0, 1'b0, 3'h0);
    step(1'b1, 1'b0, 1'b0, 1'b0, 3'h0);
    end_sim();
  end
endmodule
